// [hw/suv_pkg.sv]
// Package of constants and types for the supply undervoltage supervisor.
package suv_pkg;
  // Supply indices of the per-supply timer sets.
  localparam int SUP_BAT  = 0;
  localparam int SUP_CORE = 1;
  localparam int SUP_IO   = 2;
  localparam int NSUP     = 3;

  // Register map and status field positions.
  localparam logic [3:0] STAT_OFS    = 4'h0;
  localparam int         STAT_W      = 16;
  localparam int         BIT_BUS_ERR = 4;
  localparam int         BIT_UV_BAT  = 8;
  localparam int         BIT_UV_CORE = 9;
  localparam int         BIT_UV_IO   = 10;
  localparam int         BIT_ERR     = 11;
  localparam logic [15:0] STAT_RST   = 16'h0000;

  // Host mode command encodings on the mode pins.
  localparam logic [1:0] CMD_STBY  = 2'h0;
  localparam logic [1:0] CMD_SLEEP = 2'h1;
  localparam logic [1:0] CMD_RXO   = 2'h2;
  localparam logic [1:0] CMD_NORM  = 2'h3;

  // Times in ns and the derived cycle counts at 100 MHz.
  localparam int CLK_NS       = 10;
  localparam int BAT_BLK_NS   = 10000;
  localparam int CORE_BLK_NS  = 10000;
  localparam int IO_BLK_NS    = 10000;
  localparam int BAT_DET_NS   = 40000;
  localparam int CORE_DET_NS  = 40000;
  localparam int IO_DET_NS    = 40000;
  localparam int BAT_REC_NS   = 20000;
  localparam int CORE_REC_NS  = 20000;
  localparam int IO_REC_NS    = 20000;
  localparam int REACT_NS     = 1000;
  localparam int PWRUP_NS     = 40000;
  localparam int CW           = 12;

  // Least times round up to whole cycles.
  localparam logic [CW-1:0] BLK_CYC [NSUP] = '{
    CW'((BAT_BLK_NS + CLK_NS - 1) / CLK_NS),
    CW'((CORE_BLK_NS + CLK_NS - 1) / CLK_NS),
    CW'((IO_BLK_NS + CLK_NS - 1) / CLK_NS)};
  localparam logic [CW-1:0] DET_CYC [NSUP] = '{
    CW'((BAT_DET_NS + CLK_NS - 1) / CLK_NS),
    CW'((CORE_DET_NS + CLK_NS - 1) / CLK_NS),
    CW'((IO_DET_NS + CLK_NS - 1) / CLK_NS)};
  localparam logic [CW-1:0] REC_CYC [NSUP] = '{
    CW'((BAT_REC_NS + CLK_NS - 1) / CLK_NS),
    CW'((CORE_REC_NS + CLK_NS - 1) / CLK_NS),
    CW'((IO_REC_NS + CLK_NS - 1) / CLK_NS)};
  // Longest times round down.
  localparam logic [CW-1:0] REACT_CYC = CW'(REACT_NS / CLK_NS);
  localparam logic [CW-1:0] PWRUP_CYC = CW'(PWRUP_NS / CLK_NS);

  // Operating modes, one-hot.
  typedef enum logic [5:0] {
    MD_OFF   = 6'h01,
    MD_PROV  = 6'h02,
    MD_STBY  = 6'h04,
    MD_SLEEP = 6'h08,
    MD_NORM  = 6'h10,
    MD_RXO   = 6'h20
  } suv_mode_t;

  // Comparator levels of the three supplies, high when below threshold.
  typedef struct packed {
    logic io;
    logic core;
    logic bat;
  } suv_sup_t;
endpackage : suv_pkg

// [hw/suv_supervisor.sv]
// Supply undervoltage supervisor with mode control and status register.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A qualified undervoltage event sets its sticky bit and status bit 11.
// - Battery, core and I/O undervoltage bits sit at 8, 9 and 10.
// - Undervoltage bits stay until power-down or a status clear.
// - Undervoltage flags are unlatched, invisible, and steer modes and the host and controller interface activity.
// - Event starts a detect timer; flag sets if undervoltage remains at expiry.
// - Undervoltage ending during detection leaves the flag clear.
// - Recovery timer clears flag on expiry; returning undervoltage restarts it.
// - Cleared flags return the device to the host's last selected mode.
// - Dips no longer than a supply's blanking time are ignored.
// - Battery flag set forces sleep mode.
// - During battery detection with I/O present, host and controller stay active.
// - Core flag blocks host interface and forces standby.
// - Core undervoltage disables transmitter and sets bus error bit 4.
// - After reaction time, I/O undervoltage blocks interfaces and drives outputs low.
// - I/O undervoltage hides the register yet sets bits; flag enters sleep.
// - Both main supplies below power-down give unpowered state, outputs low.
// - Unpowered state clears every register and status.
// - Logic runs once either main supply is up; I/O takes no part.
// - With both main supplies good, standby is reached within power-up time.
// - Incomplete power-up gives provisional standby, ignoring host commands.
// - Provisional standby goes to standby or, on detect expiry, low power.
// - The error bit is shown active low on the error output, except in sleep mode without an I/O block, where the output stays high.
// - While any flag is set, normal and receive-only commands are ignored.
module suv_supervisor (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Supply comparators, asynchronous.
  input  wire suv_pkg::suv_sup_t          sup_below_uv,
  input  wire logic                       bat_below_pd,
  input  wire logic                       core_below_pd,
  // Host mode pins, asynchronous.
  input  wire logic [1:0]                 mode_cmd,
  // Register port.
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [15:0]                     reg_rdata,
  // Device outputs.
  output logic                            error_indicator_output_n,
  output logic                            tx_enable,
  output logic                            rx_enable,
  output logic                            host_if_active,
  output logic                            cc_if_active,
  output logic                            outputs_forced_low,
  output suv_pkg::suv_mode_t              mode_state
);
  localparam int N = suv_pkg::NSUP;

  logic [N-1:0]          uv_m_ff;
  logic [N-1:0]          uv_s_ff;
  logic [1:0]            pd_m_ff;
  logic [1:0]            pd_s_ff;
  logic [1:0]            cmd_m_ff;
  logic [1:0]            cmd_s_ff;
  logic [N-1:0]          uvq_ff;
  logic [N-1:0]          flag_ff;
  logic [N-1:0]          det_run_ff;
  logic [N-1:0]          evt;
  logic [suv_pkg::CW-1:0] blk_cnt_ff [N];
  logic [suv_pkg::CW-1:0] det_cnt_ff [N];
  logic [suv_pkg::CW-1:0] rec_cnt_ff [N];
  logic [15:0]           stat_ff;
  logic [15:0]           nxt_stat;
  logic [suv_pkg::CW-1:0] pu_cnt_ff;
  logic [suv_pkg::CW-1:0] react_cnt_ff;
  logic                  io_block_ff;
  logic [1:0]            host_sel_ff;
  logic                  pwr_lost;
  logic                  stat_clr;
  logic                  host_ok;
  suv_pkg::suv_mode_t    mode_ff;
  suv_pkg::suv_mode_t    nxt_mode;

  // Two-stage synchronisers for the comparator, power-down and mode pin levels.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_m_ff  <= '0;
      uv_s_ff  <= '0;
      pd_m_ff  <= 2'h3;
      pd_s_ff  <= 2'h3;
      cmd_m_ff <= 2'h0;
      cmd_s_ff <= 2'h0;
    end else begin
      uv_m_ff  <= sup_below_uv;
      uv_s_ff  <= uv_m_ff;
      pd_m_ff  <= {core_below_pd, bat_below_pd};
      pd_s_ff  <= pd_m_ff;
      cmd_m_ff <= mode_cmd;
      cmd_s_ff <= cmd_m_ff;
    end
  end

  // Power is lost only when both main supplies are below power-down.
  assign pwr_lost = &pd_s_ff;

  // Per-supply blanking, detection and recovery timers.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sup
      // Blanking: a dip must outlast the blanking count to qualify.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          blk_cnt_ff[g] <= '0;
          uvq_ff[g]     <= 1'b0;
        end else if (pwr_lost || !uv_s_ff[g]) begin
          blk_cnt_ff[g] <= '0;
          uvq_ff[g]     <= 1'b0;
        end else if (blk_cnt_ff[g] < suv_pkg::BLK_CYC[g]) begin
          blk_cnt_ff[g] <= blk_cnt_ff[g] + 1'b1;
        end else begin
          uvq_ff[g] <= 1'b1;
        end
      end

      assign evt[g] = uv_s_ff[g] && !uvq_ff[g] && !pwr_lost &&
                      blk_cnt_ff[g] == suv_pkg::BLK_CYC[g];

      // Detection timer: started by the event, aborted when the dip ends.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          det_run_ff[g] <= 1'b0;
          det_cnt_ff[g] <= '0;
        end else if (pwr_lost || !uv_s_ff[g]) begin
          det_run_ff[g] <= 1'b0;
          det_cnt_ff[g] <= '0;
        end else if (evt[g]) begin
          det_run_ff[g] <= 1'b1;
          det_cnt_ff[g] <= '0;
        end else if (det_run_ff[g]) begin
          det_cnt_ff[g] <= det_cnt_ff[g] + 1'b1;
          if (det_cnt_ff[g] == suv_pkg::DET_CYC[g] - 1'b1) begin
            det_run_ff[g] <= 1'b0;
          end
        end
      end

      // Flag and recovery timer; the flag is never a status bit.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flag_ff[g]    <= 1'b0;
          rec_cnt_ff[g] <= '0;
        end else if (pwr_lost) begin
          flag_ff[g]    <= 1'b0;
          rec_cnt_ff[g] <= '0;
        end else if (det_run_ff[g] && uv_s_ff[g] &&
                     det_cnt_ff[g] == suv_pkg::DET_CYC[g] - 1'b1) begin
          flag_ff[g]    <= 1'b1;
          rec_cnt_ff[g] <= '0;
        end else if (flag_ff[g] && uv_s_ff[g]) begin
          rec_cnt_ff[g] <= '0;
        end else if (flag_ff[g]) begin
          rec_cnt_ff[g] <= rec_cnt_ff[g] + 1'b1;
          if (rec_cnt_ff[g] == suv_pkg::REC_CYC[g] - 1'b1) begin
            flag_ff[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Register clear request; the register is unreachable while I/O is blocked.
  assign stat_clr = reg_wr && reg_addr == suv_pkg::STAT_OFS && !io_block_ff;

  // Status bits: clear first, then events, so a set wins over a clear.
  always_comb begin
    nxt_stat = stat_clr ? suv_pkg::STAT_RST : stat_ff;
    if (evt[suv_pkg::SUP_BAT]) begin
      nxt_stat[suv_pkg::BIT_UV_BAT] = 1'b1;
    end
    if (evt[suv_pkg::SUP_CORE]) begin
      nxt_stat[suv_pkg::BIT_UV_CORE] = 1'b1;
    end
    if (evt[suv_pkg::SUP_IO]) begin
      nxt_stat[suv_pkg::BIT_UV_IO] = 1'b1;
    end
    if (|evt) begin
      nxt_stat[suv_pkg::BIT_ERR] = 1'b1;
    end
    if (uvq_ff[suv_pkg::SUP_CORE]) begin
      nxt_stat[suv_pkg::BIT_BUS_ERR] = 1'b1;
    end
  end

  // Status register, wiped on loss of power.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= suv_pkg::STAT_RST;
    end else if (pwr_lost) begin
      stat_ff <= suv_pkg::STAT_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // Read port: data one cycle after the strobe, zero when blocked or unmapped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == suv_pkg::STAT_OFS && !io_block_ff) begin
      reg_rdata <= stat_ff;
    end else begin
      reg_rdata <= '0;
    end
  end

  // I/O block: set after the reaction time, released when I/O undervoltage has ended and the I/O flag is clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      react_cnt_ff <= '0;
      io_block_ff  <= 1'b0;
    end else if (pwr_lost || (!uvq_ff[suv_pkg::SUP_IO] && !flag_ff[suv_pkg::SUP_IO])) begin
      react_cnt_ff <= '0;
      io_block_ff  <= 1'b0;
    end else if (uvq_ff[suv_pkg::SUP_IO] && !io_block_ff) begin
      react_cnt_ff <= react_cnt_ff + 1'b1;
      if (react_cnt_ff == suv_pkg::REACT_CYC - 1'b1) begin
        io_block_ff <= 1'b1;
      end
    end
  end

  // Host commands are taken only when the host interface may act.
  assign host_ok = !io_block_ff && !flag_ff[suv_pkg::SUP_CORE] &&
                   mode_ff != suv_pkg::MD_PROV && mode_ff != suv_pkg::MD_OFF;

  // Last host selection, remembered for return after recovery.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_sel_ff <= suv_pkg::CMD_STBY;
    end else if (pwr_lost) begin
      host_sel_ff <= suv_pkg::CMD_STBY;
    end else if (host_ok) begin
      if (cmd_s_ff == suv_pkg::CMD_NORM || cmd_s_ff == suv_pkg::CMD_RXO) begin
        if (!(|flag_ff)) begin
          host_sel_ff <= cmd_s_ff;
        end
      end else begin
        host_sel_ff <= cmd_s_ff;
      end
    end
  end

  // Power-up counter, running only in the unpowered state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt_ff <= '0;
    end else if (pwr_lost || mode_ff != suv_pkg::MD_OFF) begin
      pu_cnt_ff <= '0;
    end else begin
      pu_cnt_ff <= pu_cnt_ff + 1'b1;
    end
  end

  // Next mode: power loss, then power-up, then flags, then host selection.
  always_comb begin
    nxt_mode = mode_ff;
    if (pwr_lost) begin
      nxt_mode = suv_pkg::MD_OFF;
    end else if (mode_ff == suv_pkg::MD_OFF) begin
      if (pu_cnt_ff == suv_pkg::PWRUP_CYC - 1'b1) begin
        if (uv_s_ff[suv_pkg::SUP_BAT] || uv_s_ff[suv_pkg::SUP_CORE]) begin
          nxt_mode = suv_pkg::MD_PROV;
        end else begin
          nxt_mode = suv_pkg::MD_STBY;
        end
      end
    end else if (flag_ff[suv_pkg::SUP_BAT] || flag_ff[suv_pkg::SUP_IO]) begin
      nxt_mode = suv_pkg::MD_SLEEP;
    end else if (flag_ff[suv_pkg::SUP_CORE]) begin
      nxt_mode = suv_pkg::MD_STBY;
    end else if (mode_ff == suv_pkg::MD_PROV) begin
      if (!uv_s_ff[suv_pkg::SUP_BAT] && !uv_s_ff[suv_pkg::SUP_CORE]) begin
        nxt_mode = suv_pkg::MD_STBY;
      end
    end else begin
      unique case (host_sel_ff)
        suv_pkg::CMD_STBY:  nxt_mode = suv_pkg::MD_STBY;
        suv_pkg::CMD_SLEEP: nxt_mode = suv_pkg::MD_SLEEP;
        suv_pkg::CMD_RXO:   nxt_mode = suv_pkg::MD_RXO;
        suv_pkg::CMD_NORM:  nxt_mode = suv_pkg::MD_NORM;
      endcase
    end
  end

  // Mode register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= suv_pkg::MD_OFF;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Registered outputs; unpowered or I/O blocked drives the enables and error output low and outputs_forced_low high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_indicator_output_n <= 1'b0;
      tx_enable                <= 1'b0;
      rx_enable                <= 1'b0;
      host_if_active           <= 1'b0;
      cc_if_active             <= 1'b0;
      outputs_forced_low       <= 1'b1;
      mode_state               <= suv_pkg::MD_OFF;
    end else begin
      mode_state <= nxt_mode;
      if (pwr_lost || nxt_mode == suv_pkg::MD_OFF || io_block_ff) begin
        error_indicator_output_n <= 1'b0;
        tx_enable                <= 1'b0;
        rx_enable                <= 1'b0;
        host_if_active           <= 1'b0;
        cc_if_active             <= 1'b0;
        outputs_forced_low       <= 1'b1;
      end else begin
        // Error shown active low except in sleep, where it stays high.
        error_indicator_output_n <= !(nxt_stat[suv_pkg::BIT_ERR] &&
                                      nxt_mode != suv_pkg::MD_SLEEP);
        tx_enable          <= nxt_mode == suv_pkg::MD_NORM &&
                              !uvq_ff[suv_pkg::SUP_CORE];
        rx_enable          <= nxt_mode == suv_pkg::MD_NORM ||
                              nxt_mode == suv_pkg::MD_RXO;
        host_if_active     <= !flag_ff[suv_pkg::SUP_CORE] &&
                              !flag_ff[suv_pkg::SUP_BAT];
        cc_if_active       <= !flag_ff[suv_pkg::SUP_BAT] &&
                              !flag_ff[suv_pkg::SUP_IO];
        outputs_forced_low <= 1'b0;
      end
    end
  end

  // Checks on the behaviour above.
  sequence s_short_dip;
    $rose(uv_s_ff[0]) ##1 !uv_s_ff[0];
  endsequence
  sequence s_bat_flag_up;
    $rose(flag_ff[0]) && !pwr_lost;
  endsequence

  AST_ERR_WITH_UV: assert property (@(posedge clk) disable iff (!rst_n)
    (|evt && !pwr_lost) |=> stat_ff[suv_pkg::BIT_ERR])
    else $error("Error bit not set with undervoltage bit.");
  AST_UV_BIT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (stat_ff[suv_pkg::BIT_UV_BAT] && !stat_clr && !pwr_lost) |=> stat_ff[suv_pkg::BIT_UV_BAT])
    else $error("Battery undervoltage bit lost without clear.");
  AST_FLAG_NEEDS_UV: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(flag_ff[1]) |-> $past(uv_s_ff[1]) && $past(det_run_ff[1]))
    else $error("Core flag set without running detection.");
  AST_SHORT_DIP: assert property (@(posedge clk) disable iff (!rst_n)
    s_short_dip |-> ##1 !uvq_ff[0])
    else $error("Short battery dip was qualified.");
  AST_BAT_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    s_bat_flag_up |=> mode_ff == suv_pkg::MD_SLEEP)
    else $error("Battery flag did not force sleep.");
  AST_CORE_TX_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (uvq_ff[1] && !pwr_lost) |=> !tx_enable ##0 stat_ff[suv_pkg::BIT_BUS_ERR])
    else $error("Transmitter on or bus error clear in core undervoltage.");
  AST_OFF_WIPE: assert property (@(posedge clk) disable iff (!rst_n)
    pwr_lost |=> stat_ff == '0 && mode_ff == suv_pkg::MD_OFF && !rx_enable)
    else $error("Unpowered state kept state or outputs.");
  AST_NO_NORMAL: assert property (@(posedge clk) disable iff (!rst_n)
    (|flag_ff && mode_ff != suv_pkg::MD_NORM) |=> mode_ff != suv_pkg::MD_NORM)
    else $error("Normal mode entered while a flag is set.");
  AST_IO_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    io_block_ff |=> !error_indicator_output_n && !host_if_active)
    else $error("Outputs not low during I/O block.");
endmodule : suv_supervisor
`default_nettype wire

// [verif/suv_host_model.sv]
// Host microcontroller model that drives the mode pins and the register port.
`timescale 1ns/1ps
`default_nettype none
module suv_host_model (
  // Clock.
  input  wire logic        clk,
  // Register port.
  input  wire logic [15:0] reg_rdata,
  output logic [3:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  // Mode pins.
  output logic [1:0]       mode_cmd
);
  // The bus starts idle with both strobes low and the host asking for standby.
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    mode_cmd  = suv_pkg::CMD_STBY;
  end

  // One-cycle write; afterwards the lines stop showing the old value.
  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : write_reg

  // One-cycle read; the data are taken in the single cycle where they stand.
  task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : read_reg

  // Mode pins change just after a clock edge and then hold as a level.
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    mode_cmd <= m;
  endtask : set_mode
endmodule : suv_host_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench of the supply undervoltage supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              clk;
  logic              rst_n;
  suv_pkg::suv_sup_t sup;
  logic              bat_pd;
  logic              core_pd;
  logic [1:0]        mode_cmd;
  logic [3:0]        reg_addr;
  logic [15:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [15:0]       reg_rdata;
  logic              err_n;
  logic              tx_en;
  logic              rx_en;
  logic              host_act;
  logic              cc_act;
  logic              forced_low;
  suv_pkg::suv_mode_t mode;
  int                mismatches;
  int                comparisons;

  suv_supervisor dut_u (.clk(clk), .rst_n(rst_n), .sup_below_uv(sup), .bat_below_pd(bat_pd),
    .core_below_pd(core_pd), .mode_cmd(mode_cmd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .error_indicator_output_n(err_n),
    .tx_enable(tx_en), .rx_enable(rx_en), .host_if_active(host_act), .cc_if_active(cc_act),
    .outputs_forced_low(forced_low), .mode_state(mode));

  suv_host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .mode_cmd(mode_cmd));

  // The clock toggles every half period of 5 ns.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("TB: comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Compares a word and reports a mismatch at once.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Reads a register and compares it.
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    host_u.read_reg(a, d);
    chk("status", e, d);
  endtask : rd

  // Compares the mode and lets whole cycles pass.
  task automatic chkm(input suv_pkg::suv_mode_t e);
    chk("mode", {10'h000, e}, {10'h000, mode});
  endtask : chkm

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Comparator levels change just after a clock edge.
  task automatic sup_set(input logic [2:0] v);
    @(posedge clk);
    sup <= v;
  endtask : sup_set

  // A run some 40 percent longer than all tests together counts as a hang.
  initial begin
    #600000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence of scenarios.
  initial begin
    mismatches = 0;
    comparisons = 0;
    rst_n = 1'b0;
    sup = 3'b000;
    bat_pd = 1'b0;
    core_pd = 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(4100);
    chkm(suv_pkg::MD_STBY);
    rd(suv_pkg::STAT_OFS, 16'h0000);
    host_u.set_mode(suv_pkg::CMD_NORM);
    cyc(6);
    chkm(suv_pkg::MD_NORM);
    chk("tx", 16'h0001, {15'h0000, tx_en});
    // Receive-only and sleep by command, then back to normal.
    host_u.set_mode(suv_pkg::CMD_RXO);
    cyc(6);
    chkm(suv_pkg::MD_RXO);
    chk("tx_rx", 16'h0001, {14'h0000, tx_en, rx_en});
    host_u.set_mode(suv_pkg::CMD_SLEEP);
    cyc(6);
    chkm(suv_pkg::MD_SLEEP);
    chk("tx_rx", 16'h0000, {14'h0000, tx_en, rx_en});
    host_u.set_mode(suv_pkg::CMD_NORM);
    cyc(6);
    chkm(suv_pkg::MD_NORM);
    // A dip shorter than blanking leaves no trace.
    sup_set(3'b001);
    cyc(900);
    sup_set(3'b000);
    cyc(20);
    rd(suv_pkg::STAT_OFS, 16'h0000);
    // A battery event that ends while detection runs.
    sup_set(3'b001);
    cyc(1100);
    chk("err_n", 16'h0000, {15'h0000, err_n});
    chk("host", 16'h0001, {15'h0000, host_act});
    chk("cc", 16'h0001, {15'h0000, cc_act});
    sup_set(3'b000);
    cyc(5000);
    chkm(suv_pkg::MD_NORM);
    rd(suv_pkg::STAT_OFS, 16'h0900);
    host_u.write_reg(4'h5, 16'hFFFF);
    rd(suv_pkg::STAT_OFS, 16'h0900);
    host_u.write_reg(suv_pkg::STAT_OFS, 16'h0000);
    rd(suv_pkg::STAT_OFS, 16'h0000);
    // Long battery undervoltage, blocked command, bounce during recovery.
    sup_set(3'b001);
    cyc(5100);
    chkm(suv_pkg::MD_SLEEP);
    chk("err_n", 16'h0001, {15'h0000, err_n});
    chk("cc", 16'h0000, {15'h0000, cc_act});
    host_u.set_mode(suv_pkg::CMD_RXO);
    cyc(10);
    chkm(suv_pkg::MD_SLEEP);
    host_u.set_mode(suv_pkg::CMD_NORM);
    sup_set(3'b000);
    cyc(1000);
    sup_set(3'b001);
    cyc(500);
    sup_set(3'b000);
    cyc(1500);
    chkm(suv_pkg::MD_SLEEP);
    cyc(600);
    chkm(suv_pkg::MD_NORM);
    host_u.write_reg(suv_pkg::STAT_OFS, 16'h0000);
    // Core undervoltage.
    sup_set(3'b010);
    cyc(1100);
    chk("tx", 16'h0000, {15'h0000, tx_en});
    rd(suv_pkg::STAT_OFS, 16'h0A10);
    cyc(4000);
    chkm(suv_pkg::MD_STBY);
    chk("host", 16'h0000, {15'h0000, host_act});
    sup_set(3'b000);
    cyc(2100);
    chkm(suv_pkg::MD_NORM);
    host_u.write_reg(suv_pkg::STAT_OFS, 16'h0000);
    // I/O supply undervoltage.
    sup_set(3'b100);
    cyc(1150);
    chk("forced_low", 16'h0001, {15'h0000, forced_low});
    chk("host", 16'h0000, {15'h0000, host_act});
    chk("cc", 16'h0000, {15'h0000, cc_act});
    chk("err_n", 16'h0000, {15'h0000, err_n});
    rd(suv_pkg::STAT_OFS, 16'h0000);
    cyc(4000);
    chkm(suv_pkg::MD_SLEEP);
    sup_set(3'b000);
    cyc(2100);
    chk("forced_low", 16'h0000, {15'h0000, forced_low});
    rd(suv_pkg::STAT_OFS, 16'h0C00);
    // Power-down with status set, then power-up on the core supply alone.
    host_u.set_mode(suv_pkg::CMD_STBY);
    bat_pd <= 1'b1;
    core_pd <= 1'b1;
    cyc(10);
    chkm(suv_pkg::MD_OFF);
    chk("outs", 16'h0004, {13'h0000, forced_low, tx_en, rx_en});
    core_pd <= 1'b0;
    cyc(4100);
    chkm(suv_pkg::MD_STBY);
    rd(suv_pkg::STAT_OFS, 16'h0000);
    // Incomplete power-up that completes before detection ends.
    bat_pd <= 1'b1;
    core_pd <= 1'b1;
    sup_set(3'b001);
    cyc(10);
    bat_pd <= 1'b0;
    core_pd <= 1'b0;
    cyc(4100);
    chkm(suv_pkg::MD_PROV);
    host_u.set_mode(suv_pkg::CMD_NORM);
    cyc(10);
    chkm(suv_pkg::MD_PROV);
    host_u.set_mode(suv_pkg::CMD_STBY);
    sup_set(3'b000);
    cyc(100);
    chkm(suv_pkg::MD_STBY);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
